// ==== dv/sbsi_port_monitor.sv ====
// pin-level assertions and covers for the burst static ram port
`timescale 1ns/10ps
module sbsi_port_monitor (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // configuration
    input wire logic [2:0] memory_clock_divider,
    input wire logic       memory_clock_gate,
    // return and refusal
    input wire logic       rsp_valid,
    input wire logic       req_error,
    // memory pins
    input wire logic       address_oe_n,
    input wire logic       data_oe_n,
    input wire logic [3:0] region_select_n,
    input wire logic [3:0] byte_lane_enable_n,
    input wire logic       burst_addr_strobe_n,
    input wire logic       burst_output_enable_n,
    input wire logic       burst_write_enable_n,
    input wire logic       memory_clock_out,
    input wire logic       control_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic half_run;
    assign half_run = memory_clock_gate && !control_oe_n
                      && memory_clock_divider == 3'h1;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_gate_holds_high: assert property (!memory_clock_gate
        && $past(!memory_clock_gate) && $past(!memory_clock_gate, 2)
        |-> memory_clock_out) else $error("memory clock moved while gated");
    a_half_rate_toggle: assert property (half_run && $past(half_run)
        && $past(half_run, 2) && $past(rst_n, 2)
        |-> memory_clock_out != $past(memory_clock_out))
        else $error("memory clock not at half rate");
    a_one_region: assert property ($onehot0(~region_select_n))
        else $error("more than one region selected");
    a_strobe_selects: assert property (!burst_addr_strobe_n
        |-> region_select_n != 4'hf) else $error("strobe without select");
    a_read_all_lanes: assert property (!burst_output_enable_n
        && !burst_addr_strobe_n |-> byte_lane_enable_n == 4'h0)
        else $error("read without all byte lanes");
    a_read_not_write: assert property (!burst_output_enable_n
        |-> burst_write_enable_n && data_oe_n)
        else $error("output enable during write drive");
    a_write_drives: assert property (!burst_write_enable_n
        |-> !data_oe_n) else $error("write enable with bus released");
    a_hold_release: assert property (control_oe_n
        |-> address_oe_n && data_oe_n) else $error("pins driven in hold");
    a_read_return: assert property (!burst_addr_strobe_n
        && !burst_output_enable_n && $past(burst_addr_strobe_n)
        |-> ##[3:16] rsp_valid) else $error("read data never returned");

    // ------------------------------------------------------------------
    // covers
    // ------------------------------------------------------------------
    c_write: cover property (!burst_write_enable_n);
    c_read: cover property (rsp_valid);
    c_refused: cover property (req_error);
    c_hold: cover property (control_oe_n);
endmodule

bind sbsi_port sbsi_port_monitor i_mon (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .memory_clock_divider(memory_clock_divider),
    .memory_clock_gate(memory_clock_gate),
    .rsp_valid(rsp_valid), .req_error(req_error),
    .address_oe_n(address_oe_n), .data_oe_n(data_oe_n),
    .region_select_n(region_select_n),
    .byte_lane_enable_n(byte_lane_enable_n),
    .burst_addr_strobe_n(burst_addr_strobe_n),
    .burst_output_enable_n(burst_output_enable_n),
    .burst_write_enable_n(burst_write_enable_n),
    .memory_clock_out(memory_clock_out), .control_oe_n(control_oe_n)
);

// ==== dv/sbsi_port_tb_top.sv ====
// self-checking bench for the burst static ram port
`timescale 1ns/10ps
module sbsi_port_tb_top;
    typedef struct packed {
        logic        write;
        logic [1:0]  kind;
        logic [21:0] addr;
        logic [31:0] wdata;
        logic [3:0]  lanes;
        logic [31:0] exp;
    } sbsi_row_type;

    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic                   ref_clk;
    logic                   rst_n;
    logic [11:0]            region_type;
    logic [2:0]             memory_clock_divider;
    logic                   memory_clock_gate;
    logic                   hold_req;
    logic                   req_valid;
    logic                   req_ready;
    sbsi_pkg::sbsi_req_type req;
    logic                   rsp_valid;
    sbsi_pkg::sbsi_rsp_type rsp;
    logic                   req_error;
    logic [21:0]            address_o;
    logic                   address_oe_n;
    logic [31:0]            data_i;
    logic [31:0]            data_o;
    logic                   data_oe_n;
    logic [3:0]             region_select_n;
    logic [3:0]             byte_lane_enable_n;
    logic                   burst_addr_strobe_n;
    logic                   burst_output_enable_n;
    logic                   burst_write_enable_n;
    logic                   memory_clock_out;
    logic                   control_oe_n;
    logic [3:0]             seen_sel;
    int                     miscompares;
    int                     checks;
    int                     n;

    // kinds: 0 byte, 1 word, 2 double, 3 dual
    localparam sbsi_row_type ROWS [8] = '{
        {1'b1, 2'h3, 22'h000010, 32'h1234abcd, 4'hf, 32'h0},
        {1'b1, 2'h3, 22'h100011, 32'h89ef0567, 4'hf, 32'h0},
        {1'b1, 2'h3, 22'h200012, 32'hffffffff, 4'hf, 32'h0},
        {1'b1, 2'h3, 22'h200012, 32'h00000000, 4'h5, 32'h0},
        {1'b0, 2'h0, 22'h000010, 32'h0, 4'hf, 32'h000000cd},
        {1'b0, 2'h1, 22'h000010, 32'h0, 4'hf, 32'h0000abcd},
        {1'b0, 2'h2, 22'h100011, 32'h0, 4'hf, 32'h89ef0567},
        {1'b0, 2'h3, 22'h200012, 32'h0, 4'hf, 32'hff00ff00}};

    sbsi_port i_dut (.clk_en(1'b1), .*);

    sbsi_sram_model i_mem (.*);

    always @(posedge ref_clk)
        if (burst_addr_strobe_n === 1'b0)
            seen_sel <= region_select_n;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] got_of(sbsi_pkg::sbsi_rsp_type r);
        case (r.kind)
            2'h0: got_of = {24'h0, r.word_lo[7:0]};
            2'h1: got_of = {16'h0, r.word_lo};
            2'h2: got_of = {r.word_hi, r.word_lo};
            default: got_of = {r.word_lo, r.word_hi};
        endcase
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask

    // valid stays up on return, so writes can follow back to back
    task automatic send(input sbsi_row_type r);
        req = {r.write, r.kind, r.addr, r.wdata, r.lanes};
        req_valid = 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 40);
        #2;
    endtask

    task automatic wait_rsp(input sbsi_row_type r);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40)
        begin
            cycles(1);
            n++;
        end
        chk_flag(rsp_valid, 1'b1);
        chk_val(got_of(rsp), r.exp);
        chk_val({30'h0, rsp.kind}, {30'h0, r.kind});
    endtask

    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial
    begin
        #150000;
        miscompares++;
        test_done;
    end

    initial
    begin
        rst_n = 1'b0;
        region_type = 12'h924;
        memory_clock_divider = 3'h0;
        memory_clock_gate = 1'b1;
        hold_req = 1'b0;
        req_valid = 1'b0;
        req = '0;
        seen_sel = 4'hf;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        chk_val({28'h0, region_select_n}, 32'hf);
        chk_val({28'h0, byte_lane_enable_n}, 32'hf);
        chk_flag(burst_addr_strobe_n & burst_write_enable_n, 1'b1);
        chk_flag(burst_output_enable_n, 1'b1);
        chk_flag(rsp_valid, 1'b0);
        for (int d = 0; d < 2; d++)
        begin
            memory_clock_gate = 1'b0;
            cycles(4);
            chk_flag(memory_clock_out, 1'b1);
            memory_clock_divider = d[2:0];
            cycles(2);
            memory_clock_gate = 1'b1;
            cycles(4);
            for (int i = 0; i < 8; i++)
            begin
                send(ROWS[i]);
                if (!ROWS[i].write)
                begin
                    req_valid = 1'b0;
                    wait_rsp(ROWS[i]);
                    chk_val({28'h0, seen_sel},
                            {28'h0, ~(4'h1 << ROWS[i].addr[21:20])});
                end
            end
        end
        // region 3 leaves burst mode: request refused, no strobe
        region_type = 12'h524;
        seen_sel = 4'hf;
        send({1'b1, 2'h1, 22'h300013, 32'h5a5a5a5a, 4'hf, 32'h0});
        req_valid = 1'b0;
        n = 0;
        while (req_error !== 1'b1 && n < 12)
        begin
            cycles(1);
            n++;
        end
        chk_flag(req_error, 1'b1);
        cycles(8);
        chk_val({28'h0, seen_sel}, 32'hf);
        hold_req = 1'b1;
        cycles(10);
        chk_flag(address_oe_n, 1'b1);
        chk_flag(control_oe_n, 1'b1);
        chk_flag(data_oe_n, 1'b1);
        hold_req = 1'b0;
        cycles(10);
        chk_flag(address_oe_n, 1'b0);
        chk_flag(control_oe_n, 1'b0);
        test_done;
    end
endmodule

// ==== dv/sbsi_sram_model.sv ====
// behavioural pipelined burst static ram on the port's pins
`timescale 1ns/10ps
module sbsi_sram_model (
    // reset
    input wire logic        rst_n,
    // pins from the port
    input wire logic [21:0] address_o,
    input wire logic [31:0] data_o,
    input wire logic        data_oe_n,
    input wire logic [3:0]  region_select_n,
    input wire logic [3:0]  byte_lane_enable_n,
    input wire logic        burst_addr_strobe_n,
    input wire logic        burst_output_enable_n,
    input wire logic        burst_write_enable_n,
    input wire logic        memory_clock_out,
    // resolved data wire
    output logic [31:0]     data_i
);
    logic [31:0] mem [256];
    logic [7:0]  rd_addr_q;
    logic        rd_pend_q;
    logic        drive_q;
    logic [31:0] dout_q;

    always @(posedge memory_clock_out or negedge rst_n)
        if (!rst_n)
        begin
            rd_pend_q <= 1'b0;
            drive_q <= 1'b0;
            dout_q <= 32'h0;
        end
        else
        begin
            // registered output: data one edge after the pending stage
            rd_pend_q <= 1'b0;
            drive_q <= rd_pend_q;
            if (rd_pend_q)
                dout_q <= mem[rd_addr_q];
            if (region_select_n != 4'hf && !burst_addr_strobe_n)
            begin
                if (!burst_write_enable_n)
                begin
                    for (int i = 0; i < 4; i++)
                        if (!byte_lane_enable_n[i])
                            mem[address_o[7:0]][8*i +: 8] <= data_o[8*i +: 8];
                end
                else
                begin
                    rd_addr_q <= address_o[7:0];
                    rd_pend_q <= 1'b1;
                end
            end
        end

    // released bus shows the inverse, so a stale word cannot pass
    assign data_i = !data_oe_n ? data_o
                  : (drive_q && !burst_output_enable_n) ? dout_q : ~dout_q;
endmodule

// ==== rtl/sbsi_pkg.sv ====
// constants and carriers for the burst static ram port
// ----------------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------------
package sbsi_pkg;

    localparam int ADDR_W = 22;
    localparam int DATA_W = 32;
    localparam int LANE_W = 4;
    localparam int REGION_N = 4;
    localparam int TYPE_W = 3;
    localparam logic [2:0] TYPE_BURST = 3'h4;
    localparam logic [2:0] DIV_FULL = 3'h0;
    localparam logic [2:0] DIV_HALF = 3'h1;
    // region is taken from the two top address bits
    localparam int REGION_LSB = 20;
    // pipelined part: data valid two memory edges after address strobe
    localparam int READ_LAT = 2;
    localparam logic [1:0] KIND_BYTE = 2'h0;
    localparam logic [1:0] KIND_WORD = 2'h1;
    localparam logic [1:0] KIND_DOUBLE = 2'h2;
    localparam logic [1:0] KIND_DUAL = 2'h3;

    typedef struct packed {
        logic              write;
        logic [1:0]        kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANE_W-1:0] lanes;
    } sbsi_req_type;

    typedef struct packed {
        logic [1:0]        kind;
        logic [15:0]       word_lo;
        logic [15:0]       word_hi;
    } sbsi_rsp_type;

endpackage

// ==== rtl/sbsi_port.sv ====
// burst static ram port: request intake, pin sequencing, read return
`timescale 1ns/10ps
module sbsi_port (
    // clock, reset, enable
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    // configuration
    input  wire logic [11:0]                   region_type,
    input  wire logic [2:0]                    memory_clock_divider,
    input  wire logic                          memory_clock_gate,
    input  wire logic                          hold_req,
    // request stream
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire sbsi_pkg::sbsi_req_type        req,
    // read return and refusal
    output logic                               rsp_valid,
    output sbsi_pkg::sbsi_rsp_type             rsp,
    output logic                               req_error,
    // memory pins
    output logic [sbsi_pkg::ADDR_W-1:0]        address_o,
    output logic                               address_oe_n,
    input  wire logic [sbsi_pkg::DATA_W-1:0]   data_i,
    output logic [sbsi_pkg::DATA_W-1:0]        data_o,
    output logic                               data_oe_n,
    output logic [sbsi_pkg::REGION_N-1:0]      region_select_n,
    output logic [sbsi_pkg::LANE_W-1:0]        byte_lane_enable_n,
    output logic                               burst_addr_strobe_n,
    output logic                               burst_output_enable_n,
    output logic                               burst_write_enable_n,
    output logic                               memory_clock_out,
    output logic                               control_oe_n
);

    // ------------------------------------------------------------------
    // input synchronisers and request buffer
    // ------------------------------------------------------------------
    logic [1:0]                   hold_sync_q;
    logic [sbsi_pkg::DATA_W-1:0]  rd_s1_q;
    logic [sbsi_pkg::DATA_W-1:0]  rd_s2_q;
    logic                         buf_valid;
    logic                         buf_ready;
    sbsi_pkg::sbsi_req_type       buf_req;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_sync_q <= 2'h0;
            rd_s1_q <= '0;
            rd_s2_q <= '0;
        end
        else if (clk_en)
        begin
            hold_sync_q <= {hold_sync_q[0], hold_req};
            rd_s1_q <= data_i;
            rd_s2_q <= rd_s1_q;
        end
    end

    sbsi_skid #(
        .WIDTH ($bits(sbsi_pkg::sbsi_req_type))
    ) u_skid (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (req),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_req)
    );

    // ------------------------------------------------------------------
    // memory clock generation
    // ------------------------------------------------------------------
    logic mclk_q;
    logic mclk_d;
    logic full_q;
    logic full_d;
    logic rise;

    // at half rate pins change as the memory clock falls and stand at its next rise;
    // full rate passes ref_clk itself, the select moving only while high
    always_comb
    begin
        mclk_d = 1'b1;
        full_d = memory_clock_gate &&
                 (memory_clock_divider == sbsi_pkg::DIV_FULL);
        rise = 1'b1;
        if (memory_clock_divider == sbsi_pkg::DIV_HALF)
        begin
            mclk_d = memory_clock_gate ? ~mclk_q : 1'b1;
            rise = mclk_q;
        end
    end

    // ------------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_HOLD  = 3'b100
    } sbsi_state_type;

    sbsi_state_type               state_q;
    sbsi_state_type               state_d;
    logic [sbsi_pkg::ADDR_W-1:0]  addr_q;
    logic [sbsi_pkg::ADDR_W-1:0]  addr_d;
    logic [sbsi_pkg::DATA_W-1:0]  wdata_q;
    logic [sbsi_pkg::DATA_W-1:0]  wdata_d;
    logic [3:0]                   sel_n_q;
    logic [3:0]                   sel_n_d;
    logic [3:0]                   lane_n_q;
    logic [3:0]                   lane_n_d;
    logic                         ads_n_q;
    logic                         ads_n_d;
    logic                         oe_n_q;
    logic                         oe_n_d;
    logic                         we_n_q;
    logic                         we_n_d;
    logic                         drive_n_q;
    logic                         drive_n_d;
    logic                         float_q;
    logic                         float_d;
    logic [3:0]                   pipe_q;
    logic [3:0]                   pipe_d;
    logic [1:0]                   kind_pipe_q [4];
    logic [1:0]                   kind_pipe_d [4];
    logic                         err_q;
    logic                         err_d;
    logic [1:0]                   region;
    logic                         is_burst;

    always_comb
    begin
        region = buf_req.addr[sbsi_pkg::REGION_LSB +: 2];
        is_burst = (region_type[region*3 +: 3] ==
                    sbsi_pkg::TYPE_BURST);
        state_d = state_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        sel_n_d = sel_n_q;
        lane_n_d = lane_n_q;
        ads_n_d = ads_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        drive_n_d = drive_n_q;
        float_d = float_q;
        pipe_d = pipe_q;
        for (int i = 0; i < 4; i++)
        begin
            kind_pipe_d[i] = kind_pipe_q[i];
        end
        err_d = 1'b0;
        buf_ready = 1'b0;
        if (rise)
        begin
            // one-cycle strobes drop after their memory edge
            ads_n_d = 1'b1;
            we_n_d = 1'b1;
            pipe_d = {pipe_q[2:0], 1'b0};
            for (int i = 3; i > 0; i--)
            begin
                kind_pipe_d[i] = kind_pipe_q[i-1];
            end
            // output enable stands until the last data edge has passed
            oe_n_d = oe_n_q || (pipe_q[sbsi_pkg::READ_LAT-1:0] == '0);
            drive_n_d = drive_n_q || we_n_q;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (hold_sync_q[1])
                    begin
                        state_d = ST_HOLD;
                    end
                    else if (buf_valid)
                    begin
                        buf_ready = 1'b1;
                        if (!is_burst)
                        begin
                            err_d = 1'b1;
                        end
                        else
                        begin
                            addr_d = buf_req.addr;
                            sel_n_d = ~(4'h1 << region);
                            ads_n_d = 1'b0;
                            if (buf_req.write)
                            begin
                                we_n_d = 1'b0;
                                lane_n_d = ~buf_req.lanes;
                                wdata_d = buf_req.wdata;
                                drive_n_d = 1'b0;
                            end
                            else
                            begin
                                lane_n_d = 4'h0;
                                drive_n_d = 1'b1;
                                oe_n_d = 1'b0;
                                pipe_d[0] = 1'b1;
                                kind_pipe_d[0] = buf_req.kind;
                                state_d = ST_WAIT;
                            end
                        end
                    end
                end
                ST_WAIT:
                begin
                    // one read in flight keeps the bus turnaround clean
                    if (pipe_q[sbsi_pkg::READ_LAT-1])
                    begin
                        state_d = ST_IDLE;
                    end
                end
                ST_HOLD:
                begin
                    sel_n_d = 4'hf;
                    if (!hold_sync_q[1])
                    begin
                        state_d = ST_IDLE;
                    end
                end
            endcase
            float_d = (state_d == ST_HOLD);
            drive_n_d = drive_n_d || float_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mclk_q <= 1'b1;
            full_q <= 1'b0;
            state_q <= ST_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            sel_n_q <= 4'hf;
            lane_n_q <= 4'hf;
            ads_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            drive_n_q <= 1'b1;
            float_q <= 1'b0;
            pipe_q <= 4'h0;
            for (int i = 0; i < 4; i++)
            begin
                kind_pipe_q[i] <= 2'h0;
            end
            err_q <= 1'b0;
        end
        else if (clk_en)
        begin
            mclk_q <= mclk_d;
            full_q <= full_d;
            state_q <= state_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            sel_n_q <= sel_n_d;
            lane_n_q <= lane_n_d;
            ads_n_q <= ads_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            drive_n_q <= drive_n_d;
            float_q <= float_d;
            pipe_q <= pipe_d;
            for (int i = 0; i < 4; i++)
            begin
                kind_pipe_q[i] <= kind_pipe_d[i];
            end
            err_q <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // read return steering
    // ------------------------------------------------------------------
    // capture waits out the two synchroniser stages, late enough for
    // the data window at either memory clock rate
    logic                    cap;
    logic                    rv_q;
    logic                    rv_d;
    sbsi_pkg::sbsi_rsp_type  rsp_q;
    sbsi_pkg::sbsi_rsp_type  rsp_d;
    logic [3:0]              cap_pipe_q;
    logic [3:0]              cap_pipe_d;
    logic [1:0]              kind_c;

    always_comb
    begin
        cap_pipe_d = {cap_pipe_q[2:0],
                      rise && pipe_q[sbsi_pkg::READ_LAT-1]};
        cap = cap_pipe_q[2];
        kind_c = kind_pipe_q[sbsi_pkg::READ_LAT];
        rv_d = cap;
        rsp_d = rsp_q;
        if (cap)
        begin
            rsp_d.kind = kind_c;
            unique case (kind_c)
                sbsi_pkg::KIND_BYTE:
                begin
                    rsp_d.word_lo = {8'h00, rd_s2_q[7:0]};
                    rsp_d.word_hi = 16'h0000;
                end
                sbsi_pkg::KIND_WORD:
                begin
                    rsp_d.word_lo = rd_s2_q[15:0];
                    rsp_d.word_hi = 16'h0000;
                end
                sbsi_pkg::KIND_DOUBLE:
                begin
                    rsp_d.word_lo = rd_s2_q[15:0];
                    rsp_d.word_hi = rd_s2_q[31:16];
                end
                sbsi_pkg::KIND_DUAL:
                begin
                    rsp_d.word_lo = rd_s2_q[31:16];
                    rsp_d.word_hi = rd_s2_q[15:0];
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rv_q <= 1'b0;
            rsp_q <= '0;
            cap_pipe_q <= 4'h0;
        end
        else if (clk_en)
        begin
            rv_q <= rv_d;
            rsp_q <= rsp_d;
            cap_pipe_q <= cap_pipe_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rsp_valid = rv_q;
    assign rsp = rsp_q;
    assign req_error = err_q;
    assign address_o = addr_q;
    assign address_oe_n = float_q;
    assign data_o = wdata_q;
    assign data_oe_n = drive_n_q;
    assign region_select_n = sel_n_q;
    assign byte_lane_enable_n = lane_n_q;
    assign burst_addr_strobe_n = ads_n_q;
    assign burst_output_enable_n = oe_n_q;
    assign burst_write_enable_n = we_n_q;
    assign memory_clock_out = full_q ? ref_clk : mclk_q;
    assign control_oe_n = float_q;

endmodule

// ==== rtl/sbsi_skid.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sbsi_skid #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [WIDTH-1:0] slot_q [2];
    logic [WIDTH-1:0] slot_d [2];
    logic [1:0]       count_q;
    logic [1:0]       count_d;
    logic             push;
    logic             pop;

    always_comb
    begin
        push = in_valid && (count_q != 2'h2);
        pop = out_ready && (count_q != 2'h0);
        slot_d[0] = slot_q[0];
        slot_d[1] = slot_q[1];
        count_d = count_q;
        if (pop)
        begin
            slot_d[0] = slot_q[1];
        end
        if (push)
        begin
            if ((count_q == 2'h0) || (count_q == 2'h1 && pop))
            begin
                slot_d[0] = in_data;
            end
            else
            begin
                slot_d[1] = in_data;
            end
        end
        count_d = count_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_q[0] <= '0;
            slot_q[1] <= '0;
            count_q <= 2'h0;
        end
        else if (clk_en)
        begin
            slot_q[0] <= slot_d[0];
            slot_q[1] <= slot_d[1];
            count_q <= count_d;
        end
    end

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = slot_q[0];

endmodule
